// [core/fifo_dma_consts.svh]
/*
 Named constants of the word sequencer: register offsets, field positions, pin
 positions and timing counts. Assumes a 100 MHz core clock.
*/
`ifndef FIFO_DMA_CONSTS_SVH
`define FIFO_DMA_CONSTS_SVH
// clock and times
`define FD_CLK_PERIOD_NS 10
`define FD_T_FLUSH_NS 400
`define FD_T_STOP_NS 150
`define FD_T_XFER_NS 45
`define FD_FLUSH_CYC ((`FD_T_FLUSH_NS + `FD_CLK_PERIOD_NS - 1) / `FD_CLK_PERIOD_NS)
`define FD_STOP_CYC ((`FD_T_STOP_NS + `FD_CLK_PERIOD_NS - 1) / `FD_CLK_PERIOD_NS)
`define FD_XFER_CYC ((`FD_T_XFER_NS + `FD_CLK_PERIOD_NS - 1) / `FD_CLK_PERIOD_NS)
// widths
`define FD_DATA_W 18
`define FD_WORD_W 19
`define FD_CELL_W 20
`define FD_STOP_BIT 19
`define FD_PAR_BIT 18
`define FD_FIFO_DEPTH 16
`define FD_FIFO_AW 4
`define FD_WC_W 16
// apb map
`define FD_ADDR_W 12
`define FD_REG_CTRL 12'h000
`define FD_REG_STATUS 12'h004
`define FD_REG_WCOUNT 12'h008
`define FD_REG_DATA 12'h00c
// control fields
`define FD_CTRL_CMD 0
`define FD_CTRL_GO 2
`define FD_CTRL_CLEAR 3
`define FD_CTRL_BUSA 4
`define FD_CTRL_ERRCLR 5
// pin vector positions
`define FD_P_GRANT 0
`define FD_P_MSW 1
`define FD_P_DMS 2
`define FD_P_DONE 3
`define FD_P_DSYNC 4
`define FD_P_EXC 5
`define FD_P_JUMP 6
`define FD_CTL_W 7
`define FD_P_BUSA 7
`define FD_P_BUSB 25
`define FD_P_DRIVE 43
`define FD_PIN_W 62
`endif

// [core/fifo_dma_pkg.sv]
/*
 Types of the word sequencer; its FIFO does not import them.
 Assumes fifo_dma_consts.svh is compiled alongside.
*/
package fifo_dma_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_REQ = 5'h02,
      ST_CYC1 = 5'h04,
      ST_CYC2 = 5'h08,
      ST_REL = 5'h10
   } seq_state_type;
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_READ = 2'h2,
      CMD_WCHK = 2'h3
   } cmd_type;
endpackage

// [core/word_fifo.sv]
/*
 Word FIFO between the input register and the holding register.
 Assumes push only when in_ready and pop only when out_valid; flush is synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fifo_dma_consts.svh"
module word_fifo (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   // fill side
   input wire logic push,
   input wire logic [`FD_CELL_W-1:0] push_data,
   output logic in_ready,
   // drain side
   input wire logic pop,
   output logic out_valid,
   output logic [`FD_CELL_W-1:0] out_data
);
   typedef struct packed {
      logic [`FD_FIFO_DEPTH-1:0][`FD_CELL_W-1:0] mem;
      logic [`FD_FIFO_AW-1:0] wr;
      logic [`FD_FIFO_AW-1:0] rd;
      logic [`FD_FIFO_AW:0] cnt;
   } fifo_state_type;
   fifo_state_type s, n;
   localparam logic [`FD_FIFO_AW:0] FULL_CNT = (`FD_FIFO_AW+1)'(`FD_FIFO_DEPTH);

   assign in_ready = s.cnt != FULL_CNT;
   assign out_valid = s.cnt != '0;
   assign out_data = s.mem[s.rd];

   always_comb begin
      n = s;
      if (push) begin
         n.mem[s.wr] = push_data;
         n.wr = s.wr + 1'b1;
      end
      if (pop) begin
         n.rd = s.rd + 1'b1;
      end
      n.cnt = s.cnt + {{`FD_FIFO_AW{1'b0}}, push} - {{`FD_FIFO_AW{1'b0}}, pop};
      if (flush) begin
         n.wr = '0;
         n.rd = '0;
         n.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule
`default_nettype wire

// [core/fifo_dma_request_sequencer.sv]
/*
 Word sequencer between two host buses and a disk drive: input register, FIFO,
 holding register, request latch, single or back-to-back cycles, exception stop
 marker, write-check compare, bus muxing and driver enables, APB control.
 Assumes the host arbiter grants after the request and pulses its cycle signals
 as levels; all pins are asynchronous and are synchronised here.
*/
// Behaviour
// RULE1 - read/verify: request only with holding full, no error, read/verify command
// RULE2 - request stays latched until the bus release strobe
// RULE3 - write: request when input register empty or a FIFO load occurs
// RULE4 - write: bus busy, sample FIFO input ready at sync wait, maybe second cycle
// RULE5 - write: FIFO not ready means single cycle, release, wait for FIFO load
// RULE6 - read/verify: word at FIFO top at sync wait sets second-cycle flag
// RULE7 - read/verify: empty top inhibits second cycle and releases the bus
// RULE8 - write: word counter steps once per memory cycle on deskewed sync
// RULE9 - read/verify: word counter steps when a word enters the holding register
// RULE10 - write: saved exception immediately raises exception error
// RULE11 - read/verify: exception trailing edge saves it and pushes stop marker, 150 ns
// RULE12 - stop marker at top raises error instead of filling holding register
// RULE13 - overflow with saved exception raises exception error and transfer error
// RULE14 - transfer error halts bus activity and returns to ready at once
// RULE15 - write path host to drive; read path drive to host via input mux
// RULE16 - master selects bus A or B; not master selects bus A
// RULE17 - program loads of the data buffer come from bus A only; the code loads the input register from PWDATA instead
// RULE18 - 18 data bits plus parity; parity zero in write, carried in read
// RULE19 - write-check compares 18 bits at sync wait, error holds until cleared
// RULE20 - bus B drivers on only as master, B selected, read driving data
// RULE21 - bus B bits 16 and 17 are data only with B selected and jumper cut
// RULE22 - clear or go produces a FIFO flush of at least 400 ns
// RULE23 - flush also drops saved exception and any stop marker
`timescale 1ns/10ps
`default_nettype none
`include "fifo_dma_consts.svh"
module fifo_dma_request_sequencer (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [`FD_ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // host bus arbitration and cycle
   output logic WORD_REQUEST_LINE,
   output logic BUS_BUSY,
   output logic BUS_RELEASE_STROBE,
   input wire logic BUS_GRANT,
   input wire logic MASTER_SYNC_WAIT,
   input wire logic DESKEWED_MASTER_SYNC,
   input wire logic MEMORY_CYCLE_DONE,
   // host data buses
   input wire logic [`FD_DATA_W-1:0] BUS_A_DATA_IN,
   output logic [`FD_DATA_W-1:0] BUS_A_DATA_OUT,
   output logic BUS_A_DATA_OE,
   input wire logic [`FD_DATA_W-1:0] BUS_B_DATA_IN,
   output logic [`FD_DATA_W-1:0] BUS_B_DATA_OUT,
   output logic BUS_B_DATA_OE,
   input wire logic BUS_B_WIDTH_JUMPER_CUT,
   output logic BUS_B_UPPER_AS_DATA,
   // drive side
   input wire logic DRIVE_SYNC_CLK,
   input wire logic DRIVE_EXCEPTION,
   input wire logic [`FD_WORD_W-1:0] DRIVE_DATA_IN,
   output logic [`FD_WORD_W-1:0] DRIVE_DATA_OUT,
   // status
   output logic EXCEPTION_ERROR,
   output logic FIFO_FLUSH_PULSE
);
   import fifo_dma_pkg::*;

   typedef struct packed {
      logic [`FD_PIN_W-1:0] pin1;
      logic [`FD_PIN_W-1:0] pin2;
      logic [`FD_CTL_W-1:0] prev;
      cmd_type cmd;
      logic bus_a_sel;
      logic [`FD_WC_W-1:0] wcount;
      logic word_count_overflow;
      logic [`FD_WORD_W-1:0] input_register;
      logic input_register_full;
      logic [`FD_WORD_W-1:0] hold;
      logic hold_full;
      logic [5:0] flush_cnt;
      logic [3:0] stop_cnt;
      logic stop_pend;
      logic [2:0] xfer_cnt;
      logic exc_saved;
      logic transfer_error_flag;
      logic write_check_error;
      logic second;
      logic req;
      seq_state_type st;
      logic [31:0] prdata;
      logic [`FD_DATA_W-1:0] host_out;
      logic [`FD_WORD_W-1:0] drive_out;
   } seq_state_struct_type;
   seq_state_struct_type s, n;

   logic [`FD_CTL_W-1:0] rise, fall;
   logic wr_mode, rv_mode, master, flushing, upper_data;
   logic [`FD_DATA_W-1:0] bus_a, bus_b, bus_data_mux;
   logic [`FD_WORD_W-1:0] input_data_mux;
   logic fifo_in_ready, fifo_out_valid, fifo_push, fifo_pop, fifo_load;
   logic [`FD_CELL_W-1:0] fifo_push_data, fifo_out;
   logic stop_hit, exc_err, wc_step, drive_tick;
   logic apb_acc, apb_mapped, flush_start;

   assign rise = s.pin2[`FD_CTL_W-1:0] & ~s.prev;
   assign fall = ~s.pin2[`FD_CTL_W-1:0] & s.prev;
   assign wr_mode = s.cmd == CMD_WRITE;
   assign rv_mode = (s.cmd == CMD_READ) || (s.cmd == CMD_WCHK);
   assign master = (s.st == ST_CYC1) || (s.st == ST_CYC2);
   assign flushing = s.flush_cnt != '0;
   assign bus_a = s.pin2[`FD_P_BUSA +: `FD_DATA_W];
   // RULE21 upper bits gating
   assign upper_data = !s.bus_a_sel && s.pin2[`FD_P_JUMP];
   assign bus_b = {upper_data ? s.pin2[`FD_P_BUSB+16 +: 2] : 2'h0,
                   s.pin2[`FD_P_BUSB +: 16]};
   // RULE16 bus selection
   assign bus_data_mux = (master && !s.bus_a_sel) ? bus_b : bus_a;
   // RULE15 input mux, RULE17 bus A outside read when not master, RULE18 write parity zero
   assign input_data_mux = rv_mode ? s.pin2[`FD_P_DRIVE +: `FD_WORD_W] : {1'b0, bus_data_mux};
   // RULE11 stop marker pushed ahead of data
   assign fifo_push = !flushing && fifo_in_ready && (s.stop_pend || s.input_register_full);
   assign fifo_load = fifo_push && !s.stop_pend;
   assign fifo_push_data = s.stop_pend ? {1'b1, {`FD_WORD_W{1'b0}}} : {1'b0, s.input_register};
   assign fifo_pop = !flushing && s.xfer_cnt == 3'h1;
   // RULE12 stop marker at top
   assign stop_hit = fifo_pop && fifo_out[`FD_STOP_BIT];
   // RULE10 write exception, RULE13 overflow with exception
   assign exc_err = (s.exc_saved && (wr_mode || s.word_count_overflow)) || stop_hit;
   // RULE8 write step per cycle, RULE9 read step per unload
   assign wc_step = (wr_mode && master && rise[`FD_P_DMS]) || (rv_mode && fifo_pop && !stop_hit);
   // the drive clock is inhibited once an error or overflow is posted
   assign drive_tick = fall[`FD_P_DSYNC] && !s.transfer_error_flag && !s.word_count_overflow && !flushing;
   assign apb_acc = PSEL && PENABLE;
   assign apb_mapped = PADDR[`FD_ADDR_W-1:4] == '0;
   assign flush_start = apb_acc && PWRITE && PADDR == `FD_REG_CTRL
                        && (PWDATA[`FD_CTRL_GO] || PWDATA[`FD_CTRL_CLEAR]);

   word_fifo fifo_i (
      .clk(CLK),
      .rst_b(RST_B),
      .flush(flushing),
      .push(fifo_push),
      .push_data(fifo_push_data),
      .in_ready(fifo_in_ready),
      .pop(fifo_pop),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out)
   );

   always_comb begin
      n = s;
      n.pin1 = {DRIVE_DATA_IN, BUS_B_DATA_IN, BUS_A_DATA_IN, BUS_B_WIDTH_JUMPER_CUT,
                DRIVE_EXCEPTION, DRIVE_SYNC_CLK, MEMORY_CYCLE_DONE,
                DESKEWED_MASTER_SYNC, MASTER_SYNC_WAIT, BUS_GRANT};
      n.pin2 = s.pin1;
      n.prev = s.pin2[`FD_CTL_W-1:0];
      n.host_out = s.hold[`FD_DATA_W-1:0];
      // apb register access
      if (PSEL && !PENABLE) begin
         case (PADDR)
            `FD_REG_CTRL: n.prdata = {27'h0, s.bus_a_sel, 2'h0, s.cmd};
            `FD_REG_STATUS: n.prdata = {19'h0, s.st, s.req, flushing, s.word_count_overflow,
                                        s.exc_saved, s.write_check_error, s.transfer_error_flag, s.input_register_full, s.hold_full};
            `FD_REG_WCOUNT: n.prdata = {16'h0, s.wcount};
            `FD_REG_DATA: n.prdata = {13'h0, s.hold};
            default: n.prdata = 32'h0;
         endcase
      end
      if (apb_acc && PWRITE) begin
         case (PADDR)
            `FD_REG_CTRL: begin
               n.cmd = cmd_type'(PWDATA[`FD_CTRL_CMD +: 2]);
               n.bus_a_sel = PWDATA[`FD_CTRL_BUSA];
               if (PWDATA[`FD_CTRL_ERRCLR]) begin
                  n.write_check_error = 1'b0;
               end
            end
            `FD_REG_WCOUNT: begin
               n.wcount = PWDATA[`FD_WC_W-1:0];
               n.word_count_overflow = 1'b0;
            end
            `FD_REG_DATA: begin
               // program load of the input register, from the low 18 bits of PWDATA
               if (!rv_mode && !master && !s.input_register_full) begin
                  n.input_register = {1'b0, PWDATA[`FD_DATA_W-1:0]};
                  n.input_register_full = 1'b1;
               end
            end
            default: n.cmd = s.cmd;
         endcase
      end
      if (apb_acc && !PWRITE && PADDR == `FD_REG_DATA && !master && !s.write_check_error) begin
         n.hold_full = 1'b0;
      end
      // drive side: write sends the held word, read captures into the input register
      if (drive_tick && wr_mode && s.hold_full) begin
         n.drive_out = s.hold;
         n.hold_full = 1'b0;
      end
      if (drive_tick && rv_mode && !s.input_register_full) begin
         n.input_register = input_data_mux;
         n.input_register_full = 1'b1;
      end
      if (fifo_load) begin
         n.input_register_full = 1'b0;
      end
      // RULE11 exception trailing edge
      if (fall[`FD_P_EXC] && s.cmd != CMD_NONE) begin
         n.exc_saved = 1'b1;
         if (rv_mode) begin
            n.stop_pend = 1'b1;
            n.stop_cnt = 4'(`FD_STOP_CYC);
         end
      end
      if (s.stop_cnt != '0) begin
         n.stop_cnt = s.stop_cnt - 4'h1;
      end
      if (fifo_push && s.stop_pend) begin
         n.stop_pend = 1'b0;
      end
      // RULE12 transfer pulse into the holding register
      if (s.xfer_cnt != '0) begin
         n.xfer_cnt = s.xfer_cnt - 3'h1;
      end else if (fifo_out_valid && !s.hold_full && !s.transfer_error_flag && !flushing) begin
         n.xfer_cnt = 3'(`FD_XFER_CYC);
      end
      if (fifo_pop && !stop_hit) begin
         n.hold = fifo_out[`FD_WORD_W-1:0];
         n.hold_full = 1'b1;
      end
      if (wc_step) begin
         n.wcount = s.wcount + 16'h0001;
         if (s.wcount == 16'hffff) begin
            n.word_count_overflow = 1'b1;
         end
      end
      // request sequencer
      case (s.st)
         ST_IDLE: begin
            // RULE1 read request, RULE3 write request, RULE5 wait for load
            if (!s.transfer_error_flag && !flushing && ((rv_mode && s.hold_full) ||
                (wr_mode && !s.word_count_overflow && (!s.input_register_full || fifo_load)))) begin
               n.req = 1'b1;
               n.st = ST_REQ;
            end
         end
         ST_REQ: begin
            if (rise[`FD_P_GRANT]) begin
               n.st = ST_CYC1;
            end
         end
         ST_CYC1, ST_CYC2: begin
            // RULE4 write sample, RULE6 read sample, RULE7 inhibit second
            if (rise[`FD_P_MSW] && s.st == ST_CYC1) begin
               n.second = wr_mode ? fifo_in_ready : fifo_out_valid;
            end
            // RULE19 write-check compare
            if (rise[`FD_P_MSW] && s.cmd == CMD_WCHK
                && s.hold[`FD_DATA_W-1:0] != bus_data_mux) begin
               n.write_check_error = 1'b1;
            end
            if (rise[`FD_P_DMS] && wr_mode) begin
               n.input_register = input_data_mux;
               n.input_register_full = 1'b1;
            end
            if (rise[`FD_P_DONE]) begin
               if (rv_mode && !s.write_check_error && !n.write_check_error) begin
                  n.hold_full = 1'b0;
               end
               if (s.st == ST_CYC1 && s.second) begin
                  n.second = 1'b0;
                  n.st = ST_CYC2;
               end else begin
                  n.second = 1'b0;
                  n.st = ST_REL;
               end
            end
         end
         ST_REL: begin
            // RULE2 release clears the latch
            n.req = 1'b0;
            n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase
      if (exc_err || s.write_check_error) begin
         n.transfer_error_flag = 1'b1;
      end
      // RULE14 transfer error halts the bus at once
      if (s.transfer_error_flag) begin
         n.req = 1'b0;
         n.second = 1'b0;
         n.st = ST_IDLE;
      end
      // RULE22 flush pulse, RULE23 clears saved exception and marker
      if (s.flush_cnt != '0) begin
         n.flush_cnt = s.flush_cnt - 6'h01;
      end
      if (flush_start) begin
         n.flush_cnt = 6'(`FD_FLUSH_CYC);
      end
      if (flushing) begin
         n.input_register_full = 1'b0;
         n.hold_full = 1'b0;
         n.exc_saved = 1'b0;
         n.stop_pend = 1'b0;
         n.stop_cnt = '0;
         n.xfer_cnt = '0;
         n.transfer_error_flag = 1'b0;
         n.second = 1'b0;
         n.req = 1'b0;
         n.st = ST_IDLE;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s <= '0;
         s.st <= ST_IDLE;
      end else begin
         s <= n;
      end
   end

   assign PRDATA = s.prdata;
   assign PREADY = 1'b1;
   assign PSLVERR = apb_acc && !apb_mapped;
   assign WORD_REQUEST_LINE = s.req;
   assign BUS_BUSY = master;
   assign BUS_RELEASE_STROBE = s.st == ST_REL;
   assign BUS_A_DATA_OUT = s.host_out;
   assign BUS_B_DATA_OUT = s.host_out;
   // RULE20 driver enables, only a read moves data to the host
   assign BUS_A_DATA_OE = master && s.bus_a_sel && s.cmd == CMD_READ;
   assign BUS_B_DATA_OE = master && !s.bus_a_sel && s.cmd == CMD_READ;
   assign BUS_B_UPPER_AS_DATA = upper_data;
   assign DRIVE_DATA_OUT = s.drive_out;
   assign EXCEPTION_ERROR = exc_err;
   assign FIFO_FLUSH_PULSE = flushing;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);

   a_req_needs_cause: assert property ($rose(s.req) && rv_mode |-> $past(s.hold_full)) // RULE1
      else $error("read request without a held word");
   a_req_latched: assert property (s.req && !s.transfer_error_flag && !flushing && s.st != ST_REL |=> s.req) // RULE2
      else $error("request dropped before release");
   a_single_release: assert property (s.st == ST_CYC1 && !s.second && rise[`FD_P_DONE]
      && !s.transfer_error_flag && !flushing |=> BUS_RELEASE_STROBE ##1 !s.req) // RULE7
      else $error("single cycle did not release the bus");
   a_wc_step: assert property (wc_step && s.wcount != 16'hffff && !(apb_acc && PWRITE)
      |=> s.wcount == $past(s.wcount) + 16'h0001) // RULE9
      else $error("word counter did not step");
   a_write_exc: assert property (wr_mode && s.exc_saved |-> EXCEPTION_ERROR) // RULE10
      else $error("write exception not raised");
   a_stop_no_full: assert property (stop_hit && !s.hold_full |=> !s.hold_full) // RULE12
      else $error("stop marker filled the holding register");
   a_tre_halt: assert property (s.transfer_error_flag |=> !BUS_BUSY && !WORD_REQUEST_LINE) // RULE14
      else $error("bus still busy after transfer error");
   a_busb_drive: assert property (BUS_B_DATA_OE |-> master && !s.bus_a_sel) // RULE20
      else $error("bus B driven without selection");
   a_flush_width: assert property ($rose(FIFO_FLUSH_PULSE) |-> FIFO_FLUSH_PULSE[*8] ##31
      FIFO_FLUSH_PULSE) // RULE22
      else $error("flush pulse too short");
   a_flush_exc: assert property (FIFO_FLUSH_PULSE |=> !s.exc_saved || $rose(s.exc_saved)) // RULE23
      else $error("flush left a saved exception");
endmodule
`default_nettype wire

// [verif/host_bus_model.sv]
/*
 Host bus arbiter and memory model for the word sequencer bench.
 Assumes every pin is synchronised in the sequencer, so each level stands several cycles.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fifo_dma_consts.svh"
module host_bus_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // arbitration
   input wire logic req,
   input wire logic busy,
   output logic grant,
   // memory cycle
   output logic msw,
   output logic dms,
   output logic done,
   // data
   output logic [`FD_DATA_W-1:0] a_in,
   output logic [`FD_DATA_W-1:0] b_in,
   input wire logic a_oe,
   input wire logic [`FD_DATA_W-1:0] b_out,
   input wire logic b_oe
);
   int idx = 0;
   int ng = 0;
   int pairs = 0;
   int singles = 0;
   int ten = 0;
   int a_oe_cnt = 0;
   int b_oe_cnt = 0;
   int n;
   logic drv = 1'h0;
   logic [`FD_DATA_W-1:0] got [0:31];
   // released lines toggle so a stale word never passes for data
   always @(posedge clk) begin
      if (!rst_b) begin
         a_in <= '0;
         b_in <= '0;
      end else begin
         a_in <= drv ? (18'h3c000 | 18'(idx)) : ~a_in;
         b_in <= drv ? ~(18'h3c000 | 18'(idx)) : ~b_in;
      end
      a_oe_cnt <= a_oe_cnt + int'(a_oe === 1'h1);
      b_oe_cnt <= b_oe_cnt + int'(b_oe === 1'h1);
   end
   task automatic mem_cycle;
      drv <= 1'h1;
      repeat (3) @(posedge clk);
      msw <= 1'h1;
      repeat (4) @(posedge clk);
      dms <= 1'h1;
      repeat (4) @(posedge clk);
      done <= 1'h1;
      if (b_oe === 1'h1 && ng < 32) begin
         got[ng] = b_out;
         ng++;
      end
      repeat (4) @(posedge clk);
      {msw, dms, done, drv} <= 4'h0;
      @(posedge clk);
      idx++;
   endtask
   initial begin
      {grant, msw, dms, done} = 4'h0;
      forever begin
         @(posedge clk);
         if (rst_b === 1'h1 && req === 1'h1) begin
            // alternate prompt and slow grants
            repeat (ten % 2 ? 12 : 2) @(posedge clk);
            grant <= 1'h1;
            for (n = 0; n < 40 && busy !== 1'h1; n++) @(posedge clk);
            n = 0;
            while (busy === 1'h1 && n < 3) begin
               mem_cycle();
               repeat (6) @(posedge clk);
               n++;
            end
            grant <= 1'h0;
            pairs += int'(n == 2);
            singles += int'(n == 1);
            ten++;
            repeat (6) @(posedge clk);
         end
      end
   end
endmodule
`default_nettype wire

// [verif/fifo_dma_request_sequencer_test.sv]
/*
 Self-checking bench for the word sequencer: APB tasks, drive pulses and a host bus model.
 Assumes zero-wait APB answers and pins synchronised inside the design.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fifo_dma_consts.svh"
module fifo_dma_request_sequencer_test;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [`FD_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic req, busy, grant, msw, dms, done, a_oe, b_oe, jumper, upper, dclk, dexc, exc_err, flush;
   logic [`FD_DATA_W-1:0] a_in, b_in, b_out;
   logic [`FD_WORD_W-1:0] d_in, d_out;
   int miscompares = 0;
   int checks = 0;
   int exc_cnt = 0;
   int cnt;
   int base;
   fifo_dma_request_sequencer fifo_dma_request_sequencer_inst (
      .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .WORD_REQUEST_LINE(req), .BUS_BUSY(busy), .BUS_RELEASE_STROBE(), .BUS_GRANT(grant),
      .MASTER_SYNC_WAIT(msw), .DESKEWED_MASTER_SYNC(dms), .MEMORY_CYCLE_DONE(done),
      .BUS_A_DATA_IN(a_in), .BUS_A_DATA_OUT(), .BUS_A_DATA_OE(a_oe),
      .BUS_B_DATA_IN(b_in), .BUS_B_DATA_OUT(b_out), .BUS_B_DATA_OE(b_oe),
      .BUS_B_WIDTH_JUMPER_CUT(jumper), .BUS_B_UPPER_AS_DATA(upper),
      .DRIVE_SYNC_CLK(dclk), .DRIVE_EXCEPTION(dexc), .DRIVE_DATA_IN(d_in),
      .DRIVE_DATA_OUT(d_out), .EXCEPTION_ERROR(exc_err), .FIFO_FLUSH_PULSE(flush));
   host_bus_model host_bus_model_inst (
      .clk(clk), .rst_b(rst_b), .req(req), .busy(busy), .grant(grant), .msw(msw),
      .dms(dms), .done(done), .a_in(a_in), .b_in(b_in), .a_oe(a_oe), .b_out(b_out),
      .b_oe(b_oe));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (exc_err === 1'h1) exc_cnt++;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) miscompares++;
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic dpulse(input logic [`FD_WORD_W-1:0] w);
      {d_in, dclk} <= {w, 1'h1};
      repeat (5) @(posedge clk);
      dclk <= 1'h0;
      repeat (8) @(posedge clk);
      d_in <= ~w;
      repeat (2) @(posedge clk);
   endtask
   task automatic wait_bit(input int b);
      for (int i = 0; i < 300; i++) begin
         apb(1'h0, `FD_REG_STATUS, 32'h0);
         if (rd[b] === 1'h1) break;
         repeat (10) @(posedge clk);
      end
      chk(32'(rd[b]), 32'h1);
   endtask
   task automatic tally_and_finish;
      if (miscompares == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog sized well past the longest sequence
   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {psel, penable, pwrite, dclk, dexc, rst_b, jumper} = 7'h01;
      {paddr, pwdata, d_in} = '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      apb(1'h0, `FD_REG_STATUS, 32'h0);
      chk(rd, 32'h100);
      apb(1'h0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'h1, `FD_REG_CTRL, 32'h8);
      for (cnt = 0; flush === 1'h1 && cnt < 200; cnt++) @(posedge clk);
      chk(32'(cnt >= `FD_FLUSH_CYC && cnt < 200), 32'h1); // flush width
      // write from bus A
      apb(1'h1, `FD_REG_CTRL, 32'h15);
      repeat (60) @(posedge clk);
      chk(32'(upper), 32'h0); // bus A chosen
      for (cnt = 0; cnt < 8000 && host_bus_model_inst.idx < 18; cnt++) @(posedge clk);
      repeat (300) @(posedge clk);
      apb(1'h0, `FD_REG_WCOUNT, 32'h0);
      chk(rd, 32'(host_bus_model_inst.idx)); // count per cycle
      chk(32'(host_bus_model_inst.idx), 32'(`FD_FIFO_DEPTH + 2)); // fill stops
      chk(32'(host_bus_model_inst.pairs > 0), 32'h1); // empty FIFO pairs
      chk(32'(host_bus_model_inst.a_oe_cnt + host_bus_model_inst.b_oe_cnt), 32'h0);
      base = host_bus_model_inst.idx;
      // idle after each word so each refill meets a full FIFO: one single cycle
      for (int k = 0; k < 4; k++) begin
         dpulse(19'h7ffff);
         chk(32'(d_out), {14'h0, 18'h3c000 | 18'(k)});
         repeat (100) @(posedge clk);
      end
      repeat (300) @(posedge clk);
      chk(32'(host_bus_model_inst.idx - base), 32'h4); // refill
      chk(32'(host_bus_model_inst.singles >= 4), 32'h1); // full FIFO singles
      // read to bus B, then a drive exception
      apb(1'h1, `FD_REG_WCOUNT, 32'h0);
      apb(1'h1, `FD_REG_CTRL, 32'h6);
      base = host_bus_model_inst.pairs;
      repeat (60) @(posedge clk);
      chk(32'(upper), 32'h1); // bus B upper bits
      jumper <= 1'h0;
      repeat (5) @(posedge clk);
      chk(32'(upper), 32'h0); // jumper in, parity lines
      jumper <= 1'h1;
      chk(32'(req), 32'h0); // holding empty
      for (int k = 0; k < 7; k++) dpulse({1'(k), 18'h12340 ^ 18'(k)});
      dexc <= 1'h1;
      repeat (5) @(posedge clk);
      dexc <= 1'h0;
      wait_bit(2);
      apb(1'h0, `FD_REG_STATUS, 32'h0);
      chk(32'(rd[12:4]), 32'h011); // idle with saved flag
      chk(32'(host_bus_model_inst.ng), 32'h7); // words before marker
      for (int k = 0; k < 7; k++) begin
         chk(32'(host_bus_model_inst.got[k]), 32'(18'h12340 ^ 18'(k)));
      end
      chk(32'(exc_cnt > 0), 32'h1);
      chk(32'(host_bus_model_inst.pairs > base), 32'h1);
      chk(32'(host_bus_model_inst.a_oe_cnt), 32'h0);
      chk(32'(host_bus_model_inst.b_oe_cnt > 0), 32'h1);
      apb(1'h0, `FD_REG_WCOUNT, 32'h0);
      chk(rd, 32'h7); // steps per word
      apb(1'h1, `FD_REG_CTRL, 32'h8);
      repeat (60) @(posedge clk);
      apb(1'h0, `FD_REG_STATUS, 32'h0);
      chk(32'(rd[4] | rd[2]), 32'h0); // flush clears
      // write-check against bus A with a wrong drive word
      apb(1'h1, `FD_REG_CTRL, 32'h17);
      repeat (60) @(posedge clk);
      dpulse(19'h00001);
      wait_bit(3); // mismatch
      repeat (100) @(posedge clk);
      apb(1'h0, `FD_REG_STATUS, 32'h0);
      chk(32'(rd[3]), 32'h1); // holds
      apb(1'h1, `FD_REG_CTRL, 32'h20);
      apb(1'h0, `FD_REG_STATUS, 32'h0);
      chk(32'(rd[3]), 32'h0); // cleared
      tally_and_finish();
   end
endmodule
`default_nettype wire
